// File: shared/fpws_cfg.svh
// Offsets, field positions, keys and reset values of the page write sequencer.
// Assumes inclusion by bare name from the design files.
`ifndef FPWS_CFG_SVH
`define FPWS_CFG_SVH

// ==========================================================================
// Register offsets (byte addresses, one aligned word each)
`define FPWS_OFS_CTL 8'h00
`define FPWS_OFS_STA 8'h04
`define FPWS_OFS_AUX 8'h08
`define FPWS_OFS_LAT 8'h0C

// ==========================================================================
// Field positions
`define FPWS_CTL_KEY_MSB 7
`define FPWS_CTL_KEY_LSB 4
`define FPWS_CTL_MAP_BIT 3
`define FPWS_CTL_MODE_HI 2
`define FPWS_CTL_MODE_LO 1
`define FPWS_CTL_BUSY_BIT 0
`define FPWS_STA_SEQUENCE_ERROR_FLAG_BIT 0
`define FPWS_STA_LOADED_BIT 1
`define FPWS_AUX_BOOTEN_BIT 0
`define FPWS_LAT_ADDR_MSB 23
`define FPWS_LAT_ADDR_LSB 8
`define FPWS_LAT_DATA_MSB 7
`define FPWS_LAT_DATA_LSB 0

// ==========================================================================
// Unlock keys, sizes, map base, reset values
`define FPWS_KEY_ARM 4'h5
`define FPWS_KEY_LAUNCH 4'hA
`define FPWS_LATCH_DEPTH 128
`define FPWS_CODE_AW 16
`define FPWS_BOOT_BASE 16'hF800
`define FPWS_LATCH_CLR_VAL 8'hFF
`define FPWS_RST_KEY 4'h0
`define FPWS_RST_BIT 1'b0
`define FPWS_RESP_OKAY 2'h0
`define FPWS_RESP_SLVERR 2'h2

`endif

// File: shared/fpws_pkg.sv
// Types shared by the page write sequencer files.
// Assumes nothing of its surroundings.
package fpws_pkg;

  // ==========================================================================
  // Sequencer states and space select codes
  typedef enum logic [3:0] {
    FPWS_IDLE  = 4'b0001,
    FPWS_DELAY = 4'b0010,
    FPWS_ERASE = 4'b0100,
    FPWS_PROG  = 4'b1000
  } fpws_state_t;

  typedef enum logic [1:0] {
    FPWS_SP_USER  = 2'b00,
    FPWS_SP_XROW  = 2'b01,
    FPWS_SP_FUSE  = 2'b10,
    FPWS_SP_CLEAR = 2'b11
  } fpws_space_t;

endpackage : fpws_pkg

// File: hw/fpws_col_latch.sv
// Column latch page: byte store with per-byte loaded markers and page address.
// Assumes writes are blocked by the caller while a write operation runs.
`timescale 1ns/1ps
`default_nettype none
`include "fpws_cfg.svh"

module fpws_col_latch #(
  parameter int DEPTH = `FPWS_LATCH_DEPTH,
  parameter int AW = `FPWS_CODE_AW,
  parameter int IW = $clog2(DEPTH)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic clr,
  input wire logic [IW-1:0] rd_idx,
  output logic [7:0] rd_data,
  output logic rd_loaded,
  output logic any_loaded,
  output logic [AW-IW-1:0] page
);

  // ==========================================================================
  // Markers and page
  logic [7:0] mem [DEPTH];
  logic [DEPTH-1:0] loaded;
  logic [DEPTH-1:0] next_loaded;
  logic [AW-IW-1:0] next_page;

  always_comb begin
    next_loaded = loaded;
    next_page = page;
    if (clr) begin
      next_loaded = '0;
    end else if (wr_en) begin
      next_loaded[wr_addr[IW-1:0]] = 1'b1;
      next_page = wr_addr[AW-1:IW];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      loaded <= '0;
      page <= '0;
    end else begin
      loaded <= next_loaded;
      page <= next_page;
    end
  end

  // ==========================================================================
  // Byte store; no reset, stale bytes are never used without a marker
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= `FPWS_LATCH_CLR_VAL;
      end
    end else if (wr_en) begin
      mem[wr_addr[IW-1:0]] <= wr_data;
    end
  end

  assign rd_data = mem[rd_idx];
  assign rd_loaded = loaded[rd_idx];
  assign any_loaded = |loaded;

endmodule : fpws_col_latch
`default_nettype wire

// File: hw/fpws_top.sv
// Flash page write sequencer: AXI4-Lite registers, unlock decode, erase/program walk.
// Assumes a flash array port that takes one byte operation per valid/ready handshake,
// and a core that reports on the same clock whether code runs from the boot array.
// What this block does
// - Operation starts second cycle after unlock pair
// - Busy clears when erase and program finish
// - Boot map enable maps boot array high
// - Latches take 1 to 128 bytes, any order
// - Last loaded address gives the page
// - Erase loaded bytes first, then program them
// - Unloaded latch bytes are never touched
// - Launch with empty latches sets sequence error, except a clear-space launch
// - Latch writes ignored while operation runs
// - Keys 50h/A0h program user space
// - Keys 52h/A2h program extra row
// - Keys 54h/A4h program security byte
// - Keys 56h/A6h clear latches only
// - Latches clear after successful write
// - Unlock works only from boot array
// - Unlock pair consecutive with same space bits
// - Space bits select user, row, fuse, clear
// - Arm key not followed by launch errs
// - Error cleared by software or completion
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fpws_cfg.svh"

module fpws_top #(
  parameter int AXI_AW = 8,
  parameter int DEPTH = `FPWS_LATCH_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic exec_from_boot,
  input wire logic [`FPWS_CODE_AW-1:0] code_addr,
  output logic boot_sel,
  output logic fl_valid,
  input wire logic fl_ready,
  output logic fl_erase,
  output var fpws_pkg::fpws_space_t fl_space,
  output logic [`FPWS_CODE_AW-1:0] fl_addr,
  output logic [7:0] fl_data,
  output logic write_in_progress_flag
);
  import fpws_pkg::*;

  localparam int IW = $clog2(DEPTH);
  localparam int CAW = `FPWS_CODE_AW;
  localparam logic [AXI_AW-1:0] OFS_CTL = AXI_AW'(`FPWS_OFS_CTL);
  localparam logic [AXI_AW-1:0] OFS_STA = AXI_AW'(`FPWS_OFS_STA);
  localparam logic [AXI_AW-1:0] OFS_AUX = AXI_AW'(`FPWS_OFS_AUX);
  localparam logic [AXI_AW-1:0] OFS_LAT = AXI_AW'(`FPWS_OFS_LAT);

  function automatic logic addr_known(input logic [AXI_AW-1:0] a);
    return (a == OFS_CTL) || (a == OFS_STA) || (a == OFS_AUX) || (a == OFS_LAT);
  endfunction : addr_known

  // ==========================================================================
  // AXI4-Lite write channel
  logic aw_ok, next_aw_ok, w_ok, next_w_ok, bvalid, next_bvalid;
  logic [AXI_AW-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic [1:0] bresp, next_bresp;
  logic wr_go;

  assign s_axi_awready = !aw_ok && !bvalid;
  assign s_axi_wready = !w_ok && !bvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign wr_go = aw_ok && w_ok && !bvalid;

  always_comb begin
    next_aw_ok = aw_ok;
    next_aw_addr = aw_addr;
    next_w_ok = w_ok;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_ok = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_ok = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      next_aw_ok = 1'b0;
      next_w_ok = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = addr_known(aw_addr) ? `FPWS_RESP_OKAY : `FPWS_RESP_SLVERR;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_ok <= 1'b0;
      aw_addr <= '0;
      w_ok <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= `FPWS_RESP_OKAY;
    end else begin
      aw_ok <= next_aw_ok;
      aw_addr <= next_aw_addr;
      w_ok <= next_w_ok;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
    end
  end

  // ==========================================================================
  // Register state and unlock decode
  logic [3:0] ctl_key, next_ctl_key;
  logic ctl_map, next_ctl_map, aux_en, next_aux_en, sequence_error_flag, next_sequence_error_flag;
  fpws_space_t ctl_mode, next_ctl_mode, armed_mode, next_armed_mode;
  fpws_space_t run_mode, next_run_mode;
  logic armed, next_armed, boot_q, next_boot_q;
  fpws_state_t st, next_st;
  logic [IW-1:0] idx, next_idx;
  logic is_ctl, launch_go, seq_bad, seq_set, seq_done, sw_clr, lat_we, lat_clr;
  logic busy, advance, lat_any, rd_loaded;
  logic [3:0] key;
  fpws_space_t wr_mode;
  logic [CAW-IW-1:0] page;
  logic [7:0] rd_data;

  assign key = w_data[`FPWS_CTL_KEY_MSB:`FPWS_CTL_KEY_LSB];
  assign wr_mode = fpws_space_t'(w_data[`FPWS_CTL_MODE_HI:`FPWS_CTL_MODE_LO]);
  assign is_ctl = wr_go && (aw_addr == OFS_CTL) && w_strb[0];
  assign sw_clr = wr_go && (aw_addr == OFS_STA) && w_strb[0] && w_data[`FPWS_STA_SEQUENCE_ERROR_FLAG_BIT];
  // Blocked from launch until the walk ends, so the captured page stays intact
  assign lat_we = wr_go && (aw_addr == OFS_LAT) && w_strb[0] && ctl_map && (st == FPWS_IDLE);
  assign busy = (st == FPWS_ERASE) || (st == FPWS_PROG);
  assign write_in_progress_flag = busy;

  always_comb begin
    next_ctl_key = ctl_key;
    next_ctl_map = ctl_map;
    next_ctl_mode = ctl_mode;
    next_aux_en = aux_en;
    next_armed = armed;
    next_armed_mode = armed_mode;
    launch_go = 1'b0;
    seq_bad = 1'b0;
    if (is_ctl) begin
      next_ctl_key = key;
      next_ctl_map = w_data[`FPWS_CTL_MAP_BIT];
      next_ctl_mode = wr_mode;
    end
    if (wr_go && (aw_addr == OFS_AUX) && w_strb[0]) begin
      next_aux_en = w_data[`FPWS_AUX_BOOTEN_BIT];
    end
    if (wr_go) begin
      if (armed) begin
        next_armed = 1'b0;
        if (is_ctl && (key == `FPWS_KEY_LAUNCH) && (wr_mode == armed_mode)) begin
          // Ignored, not an error, when code runs outside the boot array
          launch_go = exec_from_boot && (st == FPWS_IDLE);
        end else begin
          seq_bad = 1'b1;
          if (is_ctl && (key == `FPWS_KEY_ARM)) begin
            next_armed = 1'b1;
            next_armed_mode = wr_mode;
          end
        end
      end else if (is_ctl && (key == `FPWS_KEY_ARM)) begin
        next_armed = 1'b1;
        next_armed_mode = wr_mode;
      end
    end
  end

  // ==========================================================================
  // Erase and program walk over the latch page
  assign advance = busy && (!rd_loaded || fl_ready);

  always_comb begin
    next_st = st;
    next_idx = idx;
    next_run_mode = run_mode;
    seq_set = 1'b0;
    seq_done = 1'b0;
    lat_clr = 1'b0;
    unique case (st)
      FPWS_IDLE: begin
        if (launch_go) begin
          next_st = FPWS_DELAY;
          next_run_mode = armed_mode;
        end
      end
      FPWS_DELAY: begin
        next_idx = '0;
        if (run_mode == FPWS_SP_CLEAR) begin
          lat_clr = 1'b1;
          next_st = FPWS_IDLE;
        end else if (!lat_any) begin
          seq_set = 1'b1;
          next_st = FPWS_IDLE;
        end else begin
          next_st = FPWS_ERASE;
        end
      end
      FPWS_ERASE: begin
        if (advance) begin
          next_idx = IW'(idx + 1'b1);
          if (&idx) begin
            next_st = FPWS_PROG;
          end
        end
      end
      FPWS_PROG: begin
        if (advance) begin
          next_idx = IW'(idx + 1'b1);
          if (&idx) begin
            next_st = FPWS_IDLE;
            lat_clr = 1'b1;
            seq_done = 1'b1;
          end
        end
      end
    endcase
    // Set wins over either clear
    if (seq_set || seq_bad) begin
      next_sequence_error_flag = 1'b1;
    end else if (seq_done || sw_clr) begin
      next_sequence_error_flag = 1'b0;
    end else begin
      next_sequence_error_flag = sequence_error_flag;
    end
    next_boot_q = aux_en && (code_addr >= `FPWS_BOOT_BASE);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctl_key <= `FPWS_RST_KEY;
      ctl_map <= `FPWS_RST_BIT;
      ctl_mode <= FPWS_SP_USER;
      aux_en <= `FPWS_RST_BIT;
      armed <= `FPWS_RST_BIT;
      armed_mode <= FPWS_SP_USER;
      run_mode <= FPWS_SP_USER;
      sequence_error_flag <= `FPWS_RST_BIT;
      boot_q <= `FPWS_RST_BIT;
      st <= FPWS_IDLE;
      idx <= '0;
    end else begin
      ctl_key <= next_ctl_key;
      ctl_map <= next_ctl_map;
      ctl_mode <= next_ctl_mode;
      aux_en <= next_aux_en;
      armed <= next_armed;
      armed_mode <= next_armed_mode;
      run_mode <= next_run_mode;
      sequence_error_flag <= next_sequence_error_flag;
      boot_q <= next_boot_q;
      st <= next_st;
      idx <= next_idx;
    end
  end

  assign boot_sel = boot_q;
  assign fl_valid = busy && rd_loaded;
  assign fl_erase = (st == FPWS_ERASE);
  assign fl_space = run_mode;
  assign fl_addr = {page, idx};
  assign fl_data = rd_data;

  fpws_col_latch #(.DEPTH(DEPTH), .AW(CAW)) u_latch (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(lat_we),
    .wr_addr(w_data[`FPWS_LAT_ADDR_MSB:`FPWS_LAT_ADDR_LSB]),
    .wr_data(w_data[`FPWS_LAT_DATA_MSB:`FPWS_LAT_DATA_LSB]),
    .clr(lat_clr),
    .rd_idx(idx),
    .rd_data(rd_data),
    .rd_loaded(rd_loaded),
    .any_loaded(lat_any),
    .page(page)
  );

  // ==========================================================================
  // AXI4-Lite read channel
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rd_word;

  always_comb begin
    rd_word = '0;
    if (s_axi_araddr == OFS_CTL) begin
      rd_word[`FPWS_CTL_KEY_MSB:`FPWS_CTL_KEY_LSB] = ctl_key;
      rd_word[`FPWS_CTL_MAP_BIT] = ctl_map;
      rd_word[`FPWS_CTL_MODE_HI:`FPWS_CTL_MODE_LO] = ctl_mode;
      rd_word[`FPWS_CTL_BUSY_BIT] = busy;
    end else if (s_axi_araddr == OFS_STA) begin
      rd_word[`FPWS_STA_SEQUENCE_ERROR_FLAG_BIT] = sequence_error_flag;
      rd_word[`FPWS_STA_LOADED_BIT] = lat_any;
    end else if (s_axi_araddr == OFS_AUX) begin
      rd_word[`FPWS_AUX_BOOTEN_BIT] = aux_en;
    end
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata = rd_word;
      next_rresp = addr_known(s_axi_araddr) ? `FPWS_RESP_OKAY : `FPWS_RESP_SLVERR;
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `FPWS_RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic run_go;
  assign run_go = launch_go && lat_any && (armed_mode != FPWS_SP_CLEAR);

  property p_launch_delay;
    run_go |=> !busy ##1 busy;
  endproperty
  a_launch_delay: assert property (p_launch_delay) else $error("busy not raised at second cycle");

  property p_busy_end;
    (st == FPWS_PROG) && advance && (&idx) && !seq_bad |=> !busy && !lat_any && !sequence_error_flag;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("completion did not clean up");

  property p_empty_err;
    launch_go && !lat_any && (armed_mode != FPWS_SP_CLEAR) |=> !busy ##1 (sequence_error_flag && !busy);
  endproperty
  a_empty_err: assert property (p_empty_err) else $error("empty launch not flagged");

  property p_no_latch_wr;
    busy |=> $stable(page);
  endproperty
  a_no_latch_wr: assert property (p_no_latch_wr) else $error("latch written during operation");

  property p_only_loaded;
    busy && !rd_loaded |=> $changed(idx) || !busy;
  endproperty
  a_only_loaded: assert property (p_only_loaded) else $error("unloaded byte touched");

  property p_erase_first;
    (st == FPWS_ERASE) && advance && (&idx) |=> (st == FPWS_PROG) && (idx == '0) && !fl_erase;
  endproperty
  a_erase_first: assert property (p_erase_first) else $error("program phase order wrong");

  property p_seq_err;
    wr_go && armed && !(is_ctl && (key == `FPWS_KEY_LAUNCH)) |=> sequence_error_flag;
  endproperty
  a_seq_err: assert property (p_seq_err) else $error("broken unlock not flagged");

  property p_not_boot;
    wr_go && armed && (st == FPWS_IDLE) && !exec_from_boot |=> (st == FPWS_IDLE);
  endproperty
  a_not_boot: assert property (p_not_boot) else $error("unlock honored outside boot array");

  property p_clear_only;
    launch_go && (armed_mode == FPWS_SP_CLEAR) |=> ##1 (!lat_any && !busy) [*2];
  endproperty
  a_clear_only: assert property (p_clear_only) else $error("clear launch misbehaved");

  property p_boot_map;
    aux_en && (code_addr >= `FPWS_BOOT_BASE) |=> boot_sel;
  endproperty
  a_boot_map: assert property (p_boot_map) else $error("boot array not mapped");

  property p_busy_hold;
    $rose(busy) |-> busy throughout (##[1:2] (st == FPWS_ERASE) or ##[1:2] (st == FPWS_PROG));
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped mid operation");

  c_full_run: cover property ((st == FPWS_PROG) && advance && (&idx));
  c_clear: cover property (launch_go && (armed_mode == FPWS_SP_CLEAR));
  c_bad_seq: cover property (seq_bad);
  c_empty: cover property (seq_set);

endmodule : fpws_top
`default_nettype wire

// File: sim/fpws_tb.sv
// Self-checking bench for the page write sequencer, AXI4-Lite access only.
// Assumes the design files and fpws_cfg.svh are compiled first; runs DEPTH 8.
`timescale 1ns/1ps
`default_nettype none
`include "fpws_cfg.svh"

module tb;
  import fpws_pkg::*;

  // ==========================================================================
  // Signals and design
  localparam int DEPTH = 8;
  localparam logic [7:0] CTL = `FPWS_OFS_CTL;
  localparam logic [7:0] STA = `FPWS_OFS_STA;
  localparam logic [7:0] AUX = `FPWS_OFS_AUX;
  localparam logic [7:0] LAT = `FPWS_OFS_LAT;
  logic sys_clk, rst, exec_from_boot, boot_sel, fl_valid, fl_ready, fl_erase;
  logic [7:0] s_axi_awaddr, s_axi_araddr, fl_data;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, write_in_progress_flag;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] code_addr, fl_addr;
  fpws_space_t fl_space;
  logic [26:0] q[$];
  int mismatches = 0;
  int n_checks = 0;

  fpws_top #(.AXI_AW(8), .DEPTH(DEPTH)) DUT (.sys_clk(sys_clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .exec_from_boot(exec_from_boot),
    .code_addr(code_addr), .boot_sel(boot_sel), .fl_valid(fl_valid), .fl_ready(fl_ready),
    .fl_erase(fl_erase), .fl_space(fl_space), .fl_addr(fl_addr), .fl_data(fl_data),
    .write_in_progress_flag(write_in_progress_flag));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Flash side stalls every other cycle, so each byte op waits at times
  always @(posedge sys_clk) begin
    fl_ready <= ~fl_ready;
    if (fl_valid && fl_ready) q.push_back({fl_erase, fl_space, fl_addr, fl_data});
  end

  // ==========================================================================
  // Checks and closing
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (6000) @(posedge sys_clk);
    mismatches++;
    end_sim();
  end

  // ==========================================================================
  // AXI4-Lite master; ready is judged at the falling edge, where it has settled
  task automatic wr_resp(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hs, w_hs, aw_done, w_done, b_hs;
    aw_done = 1'b0;
    w_done = 1'b0;
    b_hs = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge sys_clk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      @(posedge sys_clk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      aw_done = aw_done | aw_hs;
      w_done = w_done | w_hs;
    end
    while (!b_hs) begin
      @(negedge sys_clk);
      b_hs = s_axi_bvalid;
      if (b_hs) chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      @(posedge sys_clk);
    end
    s_axi_bready <= 1'b0;
  endtask : wr_resp

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wr_resp(a, d, `FPWS_RESP_OKAY);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic hs;
    hs = 1'b0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!hs) begin
      @(negedge sys_clk);
      hs = s_axi_arready;
      @(posedge sys_clk);
    end
    s_axi_arvalid <= 1'b0;
    hs = 1'b0;
    while (!hs) begin
      @(negedge sys_clk);
      hs = s_axi_rvalid;
      if (hs) chk($sformatf("rdata at %h", a), e, s_axi_rdata);
      if (hs) chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      @(posedge sys_clk);
    end
    s_axi_rready <= 1'b0;
  endtask : rd_chk

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (write_in_progress_flag !== 1'b0 && n < 400);
    chk("busy after walk", 32'h0, {31'h0, write_in_progress_flag});
  endtask : wait_idle

  // ==========================================================================
  // Program case: load one or two bytes (a1 last), launch, poke latches while busy
  task automatic prog_case(input logic [1:0] sp, input int n, input logic [15:0] a0,
    input logic [7:0] d0, input logic [15:0] a1, input logic [7:0] d1);
    logic [26:0] e[$];
    logic [26:0] m;
    q.delete();
    wr(CTL, {24'h0, 4'h0, 1'b1, sp, 1'b0});
    if (n == 2) wr(LAT, {8'h0, a0, d0});
    wr(LAT, {8'h0, a1, d1});
    wr(CTL, 32'h0);
    wr(CTL, {24'h0, 4'h5, 1'b0, sp, 1'b0});
    wr(CTL, {24'h0, 4'hA, 1'b0, sp, 1'b0});
    @(negedge sys_clk);
    chk("busy at launch", 32'h1, {31'h0, write_in_progress_flag});
    wr(CTL, 32'h08);
    wr(LAT, {8'h0, a1[15:3], 3'h7, 8'h77});
    @(negedge sys_clk);
    chk("busy held", 32'h1, {31'h0, write_in_progress_flag});
    rd_chk(CTL, 32'h9, `FPWS_RESP_OKAY);
    wait_idle();
    rd_chk(STA, 32'h0, `FPWS_RESP_OKAY);
    for (int ph = 1; ph >= 0; ph--) begin
      if (n == 2 && a0[2:0] < a1[2:0]) e.push_back({ph[0], sp, a1[15:3], a0[2:0], d0});
      e.push_back({ph[0], sp, a1[15:3], a1[2:0], d1});
      if (n == 2 && a0[2:0] > a1[2:0]) e.push_back({ph[0], sp, a1[15:3], a0[2:0], d0});
    end
    chk("op count", e.size(), q.size());
    for (int k = 0; k < e.size() && k < q.size(); k++) begin
      m = e[k][26] ? 27'h7FFFF00 : 27'h7FFFFFF;
      chk($sformatf("flash op %0d", k), {5'h0, e[k] & m}, {5'h0, q[k] & m});
    end
    wr(CTL, 32'h0);
  endtask : prog_case

  task automatic boot_chk(input logic [15:0] a, input logic e);
    @(posedge sys_clk);
    code_addr <= a;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("boot_sel", {31'h0, e}, {31'h0, boot_sel});
  endtask : boot_chk

  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    exec_from_boot = 1'b1;
    code_addr = 16'h0000;
    fl_ready = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(CTL, 32'h0, `FPWS_RESP_OKAY);
    rd_chk(STA, 32'h0, `FPWS_RESP_OKAY);
    rd_chk(AUX, 32'h0, `FPWS_RESP_OKAY);
    rd_chk(LAT, 32'h0, `FPWS_RESP_OKAY);
    rd_chk(8'h10, 32'h0, `FPWS_RESP_SLVERR);
    wr_resp(8'h10, 32'hFF, `FPWS_RESP_SLVERR);
    $display("test reset and map done");
    wr(CTL, 32'h50);
    wr(CTL, 32'hA0);
    rd_chk(STA, 32'h1, `FPWS_RESP_OKAY);
    wr(STA, 32'h1);
    rd_chk(STA, 32'h0, `FPWS_RESP_OKAY);
    $display("test empty launch done");
    wr(CTL, 32'h50);
    wr(CTL, 32'h00);
    rd_chk(STA, 32'h1, `FPWS_RESP_OKAY);
    prog_case(2'h0, 2, 16'h1235, 8'h5A, 16'h0F02, 8'hC3);
    prog_case(2'h1, 1, 16'h0000, 8'h00, 16'hFF85, 8'h3C);
    prog_case(2'h2, 1, 16'h0000, 8'h00, 16'h0000, 8'hA5);
    $display("test program spaces done");
    q.delete();
    wr(CTL, 32'h08);
    wr(LAT, {8'h0, 16'h2001, 8'h11});
    wr(CTL, 32'h50);
    wr(CTL, 32'hA2);
    rd_chk(STA, 32'h3, `FPWS_RESP_OKAY);
    wr(STA, 32'h1);
    exec_from_boot <= 1'b0;
    wr(CTL, 32'h50);
    wr(CTL, 32'hA0);
    repeat (4) @(posedge sys_clk);
    rd_chk(STA, 32'h2, `FPWS_RESP_OKAY);
    exec_from_boot <= 1'b1;
    wr(CTL, 32'h56);
    wr(CTL, 32'hA6);
    repeat (4) @(posedge sys_clk);
    rd_chk(STA, 32'h0, `FPWS_RESP_OKAY);
    chk("ops without launch", 32'h0, q.size());
    $display("test refused launches done");
    wr(AUX, 32'h1);
    boot_chk(16'hF800, 1'b1);
    boot_chk(16'hF7FF, 1'b0);
    boot_chk(16'hFFFF, 1'b1);
    wr(AUX, 32'h0);
    boot_chk(16'hFFFF, 1'b0);
    $display("test boot map done");
    end_sim();
  end

endmodule : tb
`default_nettype wire
